/* File: core/sdram_cmd_pkg.sv */
// command decoding constants, timing figures and shared types of the sdram command interface
// assumes one 50 MHz clock; all pin inputs are synchronous to it
package sdram_cmd_pkg;

  // ==========================================================================
  // geometry
  localparam int CLOCK_MHZ          = 50;
  localparam int BANKS              = 4;
  localparam int BANK_W             = 2;
  localparam int ADDR_W             = 12;
  localparam int ROW_W              = 12;
  localparam int COL_W              = 10;
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int DATA_W             = 8;
  localparam int MASK_W             = 1;
  localparam int MODE_W             = ADDR_W + BANK_W;
  localparam int TIMER_W            = 16;
  localparam int REFRESH_ROW_W      = 12;

  // ==========================================================================
  // timing, in their own units
  localparam int PRECHARGE_PERIOD_NS       = 20;
  localparam int REFRESH_CYCLE_TIME_NS     = 66;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 67;
  localparam int ROW_ACTIVE_MIN_TIME_NS    = 44;
  localparam int SELF_REFRESH_INTERVAL_NS  = 15625;
  localparam int LOAD_TO_COMMAND_DELAY     = 2;
  localparam int MASK_TO_HIGHZ_CYCLES      = 2;
  localparam int DEFAULT_BURST_LEN         = 4;

  // least time rounded up to whole cycles, never below one
  function automatic int cycles_min(input int ns);
    int c;
    c = (ns * CLOCK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cycles_min

  // longest time rounded down, never below one
  function automatic int cycles_max(input int ns);
    int c;
    c = (ns * CLOCK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cycles_max

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD
  } command_t;

  typedef enum logic [1:0] {BANK_IDLE, BANK_OPEN, BANK_PRECHARGING} bank_state_t;

  typedef enum logic [2:0] {
    DEV_NORMAL, DEV_REFRESHING, DEV_MODE_LOADING, DEV_SELF_REFRESH, DEV_SELF_REFRESH_EXIT
  } device_state_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [MASK_W-1:0] lane_en;
    logic [DATA_W-1:0] data;
  } write_entry_t;

  localparam int WRITE_ENTRY_W = $bits(write_entry_t);

  // strobes are active low: {row, column, write enable}
  function automatic command_t decode_command(input logic row_n, input logic col_n,
                                              input logic we_n);
    case ({row_n, col_n, we_n})
      3'b111:  return CMD_NOP;
      3'b011:  return CMD_ACTIVATE;
      3'b101:  return CMD_READ;
      3'b100:  return CMD_WRITE;
      3'b110:  return CMD_BURST_STOP;
      3'b010:  return CMD_PRECHARGE;
      3'b001:  return CMD_REFRESH;
      3'b000:  return CMD_MODE_LOAD;
      default: return CMD_NOP;
    endcase
  endfunction : decode_command

endpackage : sdram_cmd_pkg

/* File: core/sdram_write_fifo_if.sv */
// valid/ready carrier between the command interface and its write buffer
// assumes both ends share one clock
`timescale 1ns/10ps
interface sdram_write_fifo_if #(
  parameter int WIDTH = 8
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport buffer (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
  modport user   (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface : sdram_write_fifo_if

/* File: core/sdram_write_fifo.sv */
// write buffer: DEPTH words of storage plus a registered output word
// assumes DEPTH is a power of two; synchronous active-low reset
`timescale 1ns/10ps
module sdram_write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic           i_clock,
  input  wire logic           i_reset_n,
  sdram_write_fifo_if.buffer  bus
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             load;

  assign bus.in_ready = (count != (AW+1)'(DEPTH));
  assign push         = bus.in_valid && bus.in_ready;
  // refill the output word whenever it is empty or being taken
  assign load         = (count != '0) && (!bus.out_valid || bus.out_ready);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= bus.in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      case ({push, load})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      bus.out_valid <= 1'b0;
      bus.out_data  <= '0;
    end else if (load) begin
      bus.out_valid <= 1'b1;
      bus.out_data  <= mem[rd_ptr];
    end else if (bus.out_ready) begin
      bus.out_valid <= 1'b0;
    end
  end

endmodule : sdram_write_fifo

/* File: core/sdram_command_interface.sv */
// command front end of a quad-bank sdram: decode, bank state, bursts, refresh, data mask
// assumes all pin inputs synchronous to i_clock; the array answers o_rd_* in the same cycle
`timescale 1ns/10ps
module sdram_command_interface
  import sdram_cmd_pkg::*;
#(
  parameter int BURST_LEN            = DEFAULT_BURST_LEN,
  parameter int FIFO_DEPTH           = 16,
  parameter bit AUTOMOTIVE           = 1'b0,
  parameter int PRECHARGE_CYCLES     = cycles_min(PRECHARGE_PERIOD_NS),
  parameter int REFRESH_CYCLES       = cycles_min(REFRESH_CYCLE_TIME_NS),
  parameter int EXIT_CYCLES          = cycles_min(SELF_REFRESH_EXIT_TIME_NS),
  parameter int MODE_LOAD_CYCLES     = LOAD_TO_COMMAND_DELAY,
  parameter int SELF_INTERVAL_CYCLES = cycles_max(SELF_REFRESH_INTERVAL_NS)
) (
  input  wire logic                i_clock,
  input  wire logic                i_reset_n,
  input  wire logic                i_chip_select_n,
  input  wire logic                i_row_strobe_n,
  input  wire logic                i_col_strobe_n,
  input  wire logic                i_write_enable_n,
  input  wire logic                i_clock_enable,
  input  wire logic                i_bank_select_0,
  input  wire logic                i_bank_select_1,
  input  wire logic [ADDR_W-1:0]   i_address,
  input  wire logic [MASK_W-1:0]   i_data_mask,
  input  wire logic                i_full_page,
  input  wire logic [DATA_W-1:0]   i_dq,
  output logic      [DATA_W-1:0]   o_dq,
  output logic      [MASK_W-1:0]   o_dq_oe,
  output logic                     o_rd_req,
  output logic      [BANK_W-1:0]   o_rd_bank,
  output logic      [ROW_W-1:0]    o_rd_row,
  output logic      [COL_W-1:0]    o_rd_col,
  input  wire logic [DATA_W-1:0]   i_rd_data,
  output logic                     o_wr_valid,
  input  wire logic                i_wr_ready,
  output logic      [BANK_W-1:0]   o_wr_bank,
  output logic      [ROW_W-1:0]    o_wr_row,
  output logic      [COL_W-1:0]    o_wr_col,
  output logic      [MASK_W-1:0]   o_wr_lane_en,
  output logic      [DATA_W-1:0]   o_wr_data,
  output logic                     o_write_buffer_ready,
  output logic                     o_write_overflow,
  output logic                     o_refresh_req,
  output logic [REFRESH_ROW_W-1:0] o_refresh_row,
  output logic      [BANKS-1:0]    o_bank_open,
  output logic      [MODE_W-1:0]   o_mode_register,
  output logic                     o_self_refresh,
  output logic                     o_command_error
);

  // ==========================================================================
  // command decode
  command_t                      cmd;
  device_state_t                 dev_state;
  logic [TIMER_W-1:0]            dev_timer;
  bank_state_t                   bank_state [BANKS];
  logic [BANKS-1:0][ROW_W-1:0]   bank_row;
  logic [BANK_W-1:0]             bank;
  logic                          selected;
  logic                          auto_pre;
  logic                          all_idle;
  logic                          is_act;
  logic                          is_rd;
  logic                          is_wr;
  logic                          is_stop;
  logic                          is_pre;
  logic                          is_auto_ref;
  logic                          is_self_ref;
  logic                          is_load;
  logic                          access_ok;

  assign cmd      = decode_command(i_row_strobe_n, i_col_strobe_n, i_write_enable_n);
  assign selected = !i_chip_select_n && (dev_state == DEV_NORMAL);
  assign bank     = {i_bank_select_1, i_bank_select_0};
  assign auto_pre = i_address[AUTO_PRECHARGE_BIT];

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      if (bank_state[b] != BANK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  assign is_act      = selected && (cmd == CMD_ACTIVATE);
  assign is_rd       = selected && (cmd == CMD_READ);
  assign is_wr       = selected && (cmd == CMD_WRITE);
  assign is_stop     = selected && (cmd == CMD_BURST_STOP);
  assign is_pre      = selected && (cmd == CMD_PRECHARGE);
  assign is_load     = selected && (cmd == CMD_MODE_LOAD);
  assign is_auto_ref = selected && (cmd == CMD_REFRESH) && i_clock_enable;
  assign is_self_ref = selected && (cmd == CMD_REFRESH) && !i_clock_enable && !AUTOMOTIVE;
  // reads and writes only reach a bank with an open row
  assign access_ok   = (is_rd || is_wr) && (bank_state[bank] == BANK_OPEN);

  // ==========================================================================
  // burst engine
  logic                    burst_active;
  logic                    burst_write;
  logic                    burst_ap;
  logic [BANK_W-1:0]       burst_bank;
  logic [COL_W-1:0]        burst_col;
  logic [TIMER_W-1:0]      burst_left;
  logic                    beat;
  logic                    beat_write;
  logic [BANK_W-1:0]       beat_bank;
  logic [COL_W-1:0]        beat_col;
  logic                    burst_last;
  logic                    close_now;
  logic [BANK_W-1:0]       close_bank;
  logic                    burst_cut;

  assign beat       = access_ok || (burst_active && !is_stop && !burst_cut);
  assign beat_write = access_ok ? is_wr : burst_write;
  assign beat_bank  = access_ok ? bank : burst_bank;
  assign beat_col   = access_ok ? i_address[COL_W-1:0] : burst_col;
  // precharge of the bursting bank truncates the burst
  assign burst_cut  = is_pre && (auto_pre || bank == burst_bank);
  assign burst_last = access_ok ? (BURST_LEN == 1 && !i_full_page)
                                : (burst_active && !i_full_page && burst_left == TIMER_W'(1));
  assign close_now  = access_ok ? (auto_pre && burst_last)
                                : (burst_ap && burst_active && !burst_cut
                                   && (burst_last || is_stop));
  assign close_bank = beat_bank;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
      burst_ap     <= 1'b0;
      burst_bank   <= '0;
      burst_col    <= '0;
      burst_left   <= '0;
    end else if (access_ok) begin
      // a new read or write replaces whatever burst was running
      burst_active <= !burst_last;
      burst_write  <= is_wr;
      burst_ap     <= auto_pre;
      burst_bank   <= bank;
      burst_col    <= i_address[COL_W-1:0] + 1'b1;
      burst_left   <= TIMER_W'(BURST_LEN - 1);
    end else if (is_stop || burst_cut) begin
      burst_active <= 1'b0;
    end else if (burst_active) begin
      burst_col  <= burst_col + 1'b1;
      burst_left <= burst_left - 1'b1;
      if (burst_last) begin
        burst_active <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // per-bank row state
  logic [BANKS-1:0] bank_error;

  generate
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
      logic               act_hit;
      logic               pre_hit;
      logic [TIMER_W-1:0] timer;

      assign act_hit       = is_act && (bank == BANK_W'(b));
      assign pre_hit       = (is_pre && (auto_pre || bank == BANK_W'(b)))
                             || (close_now && close_bank == BANK_W'(b));
      assign bank_error[b] = act_hit && (bank_state[b] != BANK_IDLE);

      always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
          bank_state[b]  <= BANK_IDLE;
          bank_row[b]    <= '0;
          timer          <= '0;
          o_bank_open[b] <= 1'b0;
        end else begin
          case (bank_state[b])
            BANK_IDLE: begin
              if (act_hit) begin
                bank_state[b]  <= BANK_OPEN;
                bank_row[b]    <= i_address[ROW_W-1:0];
                o_bank_open[b] <= 1'b1;
              end
            end
            BANK_OPEN: begin
              if (pre_hit) begin
                bank_state[b]  <= BANK_PRECHARGING;
                timer          <= TIMER_W'(PRECHARGE_CYCLES);
                o_bank_open[b] <= 1'b0;
              end
            end
            BANK_PRECHARGING: begin
              timer <= timer - 1'b1;
              if (timer <= TIMER_W'(1)) begin
                bank_state[b] <= BANK_IDLE;
              end
            end
            default: begin
              bank_state[b] <= BANK_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // ==========================================================================
  // device state: refresh, mode load, self refresh
  logic busy_violation;

  assign busy_violation = !i_chip_select_n && (cmd != CMD_NOP)
                          && (dev_state == DEV_REFRESHING || dev_state == DEV_MODE_LOADING
                              || dev_state == DEV_SELF_REFRESH_EXIT);

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      dev_state       <= DEV_NORMAL;
      dev_timer       <= '0;
      o_self_refresh  <= 1'b0;
      o_mode_register <= '0;
    end else begin
      case (dev_state)
        DEV_NORMAL: begin
          if (is_auto_ref) begin
            dev_state <= DEV_REFRESHING;
            dev_timer <= TIMER_W'(REFRESH_CYCLES);
          end else if (is_self_ref) begin
            dev_state      <= DEV_SELF_REFRESH;
            o_self_refresh <= 1'b1;
          end else if (is_load) begin
            dev_state       <= DEV_MODE_LOADING;
            dev_timer       <= TIMER_W'(MODE_LOAD_CYCLES);
            o_mode_register <= {bank, i_address};
          end
        end
        DEV_REFRESHING, DEV_MODE_LOADING, DEV_SELF_REFRESH_EXIT: begin
          dev_timer <= dev_timer - 1'b1;
          if (dev_timer <= TIMER_W'(1)) begin
            dev_state <= DEV_NORMAL;
          end
        end
        DEV_SELF_REFRESH: begin
          if (i_clock_enable) begin
            dev_state      <= DEV_SELF_REFRESH_EXIT;
            dev_timer      <= TIMER_W'(EXIT_CYCLES);
            o_self_refresh <= 1'b0;
          end
        end
        default: begin
          dev_state <= DEV_NORMAL;
        end
      endcase
    end
  end

  // one row counter serves both refresh modes
  logic [REFRESH_ROW_W-1:0] refresh_row;
  logic [TIMER_W-1:0]       self_timer;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      refresh_row   <= '0;
      self_timer    <= '0;
      o_refresh_req <= 1'b0;
      o_refresh_row <= '0;
    end else begin
      o_refresh_req <= 1'b0;
      if (is_auto_ref || is_self_ref) begin
        o_refresh_req <= 1'b1;
        o_refresh_row <= refresh_row;
        refresh_row   <= refresh_row + 1'b1;
        self_timer    <= TIMER_W'(SELF_INTERVAL_CYCLES);
      end else if (dev_state == DEV_SELF_REFRESH) begin
        self_timer <= self_timer - 1'b1;
        if (self_timer <= TIMER_W'(1)) begin
          o_refresh_req <= 1'b1;
          o_refresh_row <= refresh_row;
          refresh_row   <= refresh_row + 1'b1;
          self_timer    <= TIMER_W'(SELF_INTERVAL_CYCLES);
        end
      end
    end
  end

  // flags commands that break bank or device state; a pulse one cycle after the edge
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_command_error <= 1'b0;
    end else begin
      o_command_error <= (|bank_error)
                         || ((is_rd || is_wr) && !access_ok)
                         || ((is_auto_ref || is_self_ref || is_load) && !all_idle)
                         || busy_violation;
    end
  end

  // ==========================================================================
  // read path: array request two clocks after the beat, data and mask three
  logic                                      rd_beat;
  logic [BANK_W-1:0]                         rd_beat_bank;
  logic [ROW_W-1:0]                          rd_beat_row;
  logic [COL_W-1:0]                          rd_beat_col;
  logic [MASK_TO_HIGHZ_CYCLES-1:0][MASK_W-1:0] mask_pipe;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rd_beat      <= 1'b0;
      rd_beat_bank <= '0;
      rd_beat_row  <= '0;
      rd_beat_col  <= '0;
      o_rd_req     <= 1'b0;
      o_rd_bank    <= '0;
      o_rd_row     <= '0;
      o_rd_col     <= '0;
    end else begin
      rd_beat      <= beat && !beat_write;
      rd_beat_bank <= beat_bank;
      rd_beat_row  <= bank_row[beat_bank];
      rd_beat_col  <= beat_col;
      o_rd_req     <= rd_beat;
      o_rd_bank    <= rd_beat_bank;
      o_rd_row     <= rd_beat_row;
      o_rd_col     <= rd_beat_col;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      mask_pipe <= '0;
      o_dq      <= '0;
      o_dq_oe   <= '0;
    end else begin
      mask_pipe <= {mask_pipe[MASK_TO_HIGHZ_CYCLES-2:0], i_data_mask};
      o_dq      <= i_rd_data;
      o_dq_oe   <= {MASK_W{o_rd_req}} & ~mask_pipe[MASK_TO_HIGHZ_CYCLES-1];
    end
  end

  // ==========================================================================
  // write path: masked lanes dropped on the spot, the rest buffered toward the array
  sdram_write_fifo_if #(.WIDTH(WRITE_ENTRY_W)) fifo_bus ();
  write_entry_t entry_in;
  write_entry_t entry_out;

  always_comb begin
    entry_in.bank    = beat_bank;
    entry_in.row     = bank_row[beat_bank];
    entry_in.col     = beat_col;
    entry_in.lane_en = ~i_data_mask;
    entry_in.data    = i_dq;
  end

  assign fifo_bus.in_valid  = beat && beat_write && (|(~i_data_mask));
  assign fifo_bus.in_data   = entry_in;
  assign fifo_bus.out_ready = i_wr_ready;
  assign entry_out          = fifo_bus.out_data;

  sdram_write_fifo #(
    .WIDTH (WRITE_ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_write_fifo (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .bus       (fifo_bus)
  );

  assign o_wr_valid   = fifo_bus.out_valid;
  assign o_wr_bank    = entry_out.bank;
  assign o_wr_row     = entry_out.row;
  assign o_wr_col     = entry_out.col;
  assign o_wr_lane_en = entry_out.lane_en;
  assign o_wr_data    = entry_out.data;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_write_buffer_ready <= 1'b0;
      o_write_overflow     <= 1'b0;
    end else begin
      o_write_buffer_ready <= fifo_bus.in_ready;
      if (fifo_bus.in_valid && !fifo_bus.in_ready) begin
        o_write_overflow <= 1'b1;
      end
    end
  end

endmodule : sdram_command_interface

/* File: tb/sdram_cmd_props.sv */
// concurrent checks on the command interface pins
// assumes binding into sdram_command_interface, one clock
`timescale 1ns/10ps
module sdram_cmd_props
  import sdram_cmd_pkg::*;
(
  input wire logic i_clock, i_reset_n, i_chip_select_n, i_clock_enable, o_command_error,
  input wire logic i_row_strobe_n, i_col_strobe_n, i_write_enable_n, o_rd_req,
  input wire logic i_bank_select_0, i_bank_select_1, o_refresh_req, o_self_refresh,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic [MASK_W-1:0] i_data_mask, o_dq_oe,
  input wire logic [BANKS-1:0]  o_bank_open,
  input wire logic [MODE_W-1:0] o_mode_register
);
  // ========
  // quiet counts idle cycles so the device is surely in its normal state
  logic [2:0] quiet;
  wire [2:0] code = {i_row_strobe_n, i_col_strobe_n, i_write_enable_n};
  wire [1:0] bank = {i_bank_select_1, i_bank_select_0};
  wire go = !i_chip_select_n && quiet > 3'h5;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || o_self_refresh || (!i_chip_select_n && code != 3'h7)) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_pulse; o_refresh_req ##1 !o_refresh_req; endsequence
  sequence s_refresh; go && code == 3'h1 && o_bank_open == 4'h0; endsequence
  a_no_command: assert property (i_chip_select_n |=> !o_command_error)
    else $error("error after deselect");
  a_act_opens: assert property (go && code == 3'h3 && !o_bank_open[bank]
    |=> o_bank_open[$past(bank)]) else $error("row not opened");
  a_read_lane: assert property (o_rd_req |=> o_dq_oe == ~$past(i_data_mask, 3))
    else $error("read lane enable wrong");
  a_auto_refresh: assert property (s_refresh ##0 i_clock_enable |=> s_pulse)
    else $error("no refresh pulse");
  a_self_enter: assert property (s_refresh ##0 !i_clock_enable |=> o_self_refresh)
    else $error("self refresh not entered");
  a_mode_load: assert property (go && code == 3'h0
    |=> o_mode_register == $past({bank, i_address})) else $error("mode load wrong");
  a_close_all: assert property (go && code == 3'h2 && i_address[AUTO_PRECHARGE_BIT]
    |=> o_bank_open == 4'h0) else $error("banks left open");
  a_read_closed: assert property (go && code == 3'h5 && !o_bank_open[bank]
    |=> o_command_error) else $error("no error on closed bank");
endmodule : sdram_cmd_props
bind sdram_command_interface sdram_cmd_props props (.*);

/* File: tb/sdram_array_model.sv */
// array stand-in behind the command interface, stalling its write side at random
// assumes one clock; read data answers the read address in the same cycle
`timescale 1ns/10ps
module sdram_array_model (
  input  wire logic        i_clock,
  input  wire logic [23:0] i_rd_key,
  input  wire logic        i_wr_valid,
  input  wire logic [23:0] i_wr_key,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_lane_en,
  output logic      [7:0]  o_rd_data,
  output logic             o_wr_ready
);
  logic [7:0] mem [int];
  always_comb o_rd_data = mem.exists(i_rd_key) ? mem[i_rd_key] : 8'h5a;
  initial o_wr_ready = 1'b0;
  always @(posedge i_clock) begin
    if (i_wr_valid && o_wr_ready && i_wr_lane_en) mem[i_wr_key] = i_wr_data;
    o_wr_ready <= 1'($urandom_range(1, 0));
  end
endmodule : sdram_array_model

/* File: tb/tb_top.sv */
// self-checking bench: bursts, precharge, refresh and self refresh
// assumes the array model answers reads in the same cycle
`timescale 1ns/10ps
module tb_top import sdram_cmd_pkg::*; ;
  // ========
  logic clk = 0, rst_n = 0, cs_n = 1, cke = 1, dm = 0, pend = 0;
  logic [2:0] code = 3'h7;
  logic [1:0] ba = 0, rb, wb;
  logic [11:0] addr = 0, rr, wr, rrow;
  logic [9:0] rc, wc;
  logic [7:0] dq = 0, rd_data, o_dq, wd;
  logic [3:0] bopen;
  logic oe, rd_req, wr_v, wr_rdy, lane, ovf, rreq, fp = 0;
  int bad_count = 0, samples_checked = 0;
  logic [8:0] q[$];
  logic [7:0] sh [int];
  always #10 clk = ~clk;
  sdram_command_interface #(.SELF_INTERVAL_CYCLES(8)) DUT (.i_clock(clk), .i_reset_n(rst_n),
    .i_chip_select_n(cs_n), .i_row_strobe_n(code[2]), .i_col_strobe_n(code[1]),
    .i_write_enable_n(code[0]), .i_clock_enable(cke), .i_bank_select_0(ba[0]),
    .i_bank_select_1(ba[1]), .i_address(addr), .i_data_mask(dm), .i_full_page(fp),
    .i_dq(dq), .o_dq(o_dq), .o_dq_oe(oe), .o_rd_req(rd_req), .o_rd_bank(rb), .o_rd_row(rr),
    .o_rd_col(rc), .i_rd_data(rd_data), .o_wr_valid(wr_v), .i_wr_ready(wr_rdy),
    .o_wr_bank(wb), .o_wr_row(wr), .o_wr_col(wc), .o_wr_lane_en(lane), .o_wr_data(wd),
    .o_write_buffer_ready(), .o_write_overflow(ovf), .o_refresh_req(rreq), .o_refresh_row(rrow),
    .o_bank_open(bopen), .o_mode_register(), .o_self_refresh(), .o_command_error());
  sdram_array_model array (.i_clock(clk), .i_rd_key({rb, rr, rc}), .i_wr_valid(wr_v),
    .i_wr_key({wb, wr, wc}), .i_wr_data(wd), .i_wr_lane_en(lane), .o_rd_data(rd_data),
    .o_wr_ready(wr_rdy));
  task automatic chk(input string name, input logic [8:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // idle gap first, so every command meets the busy times before it
  task automatic cmd(input [2:0] c, input [1:0] b, input [11:0] a, input k = 1, s = 0);
    repeat (8) @(posedge clk);
    cs_n <= s; code <= c; ba <= b; addr <= a; cke <= k;
    @(posedge clk);
    cs_n <= 0; code <= 3'h7;
  endtask : cmd
  // n beats of a read or write burst, then a burst stop in the slot after beat n
  task automatic bst(input [2:0] c, input [1:0] b, input [11:0] r, a, input int n);
    logic [7:0] d;
    logic m;
    logic [23:0] k;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      d = 8'($urandom);
      m = 1'($urandom_range(1, 0));
      k = {b, r, a[9:0] + 10'(i)};
      cs_n <= 0; code <= i == 0 ? c : (i == n ? 3'h6 : 3'h7);
      ba <= b; addr <= a; dq <= d; dm <= m;
      if (i < n && c == 3'h4 && !m) sh[k] = d;
      if (i < n && c == 3'h5) q.push_back(m ? 9'h0 : {1'b1, sh.exists(k) ? sh[k] : 8'h5a});
    end
    @(posedge clk);
    code <= 3'h7; dm <= 0;
    repeat (2) @(posedge clk);
    for (int j = 0; j < 60 && wr_v !== 1'b0; j++) @(posedge clk);
  endtask : bst
  always @(posedge clk) begin
    if (pend) chk("read lane", q.size() ? q.pop_front() : 'x, oe ? {1'b1, o_dq} : 9'h0);
    pend <= rd_req;
  end
  initial begin
    void'($urandom(43755));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    for (int b = 0; b < 4; b++) cmd(3'h3, 2'(b), 12'(b + 7));
    for (int b = 0; b < 4; b++) begin
      bst(3'h4, 2'(b), 12'(b + 7), 12'h010, 4);
      bst(3'h5, 2'(b), 12'(b + 7), 12'h010, 4);
    end
    bst(3'h5, 2'h1, 12'h008, 12'h011, 1);
    fp <= 1;
    bst(3'h5, 2'h3, 12'h00a, 12'h010, 5);
    fp <= 0;
    cmd(3'h5, 2'h0, 12'h010, 1, 1);
    bst(3'h5, 2'h0, 12'h007, 12'h410, 4);
    chk("bank open", 9'h00e, 9'(bopen));
    cmd(3'h5, 2'h0, 12'h010);
    cmd(3'h2, 2'h1, 12'h000);
    cmd(3'h2, 2'h1, 12'h400);
    @(posedge clk) chk("bank open", 9'h000, 9'(bopen));
    cmd(3'h0, 2'h2, 12'($urandom));
    cmd(3'h1, 2'h0, 12'h000);
    @(posedge clk) chk("refresh row", 9'h100, {rreq, rrow[7:0]});
    cmd(3'h1, 2'h0, 12'h000, 0);
    cmd(3'h3, 2'h1, 12'h005, 0);
    cmd(3'h7, 2'h0, 12'h000, 1);
    cmd(3'h1, 2'h0, 12'h000);
    cmd(3'h3, 2'h2, 12'h005);
    repeat (2) @(posedge clk);
    chk("bank open", 9'h004, 9'(bopen));
    chk("overflow", 9'h000, 9'(ovf));
    chk("reads left", 9'h000, 9'(q.size()));
    results();
  end
  initial begin
    #100_000;
    bad_count++;
    results();
  end
endmodule : tb_top
